// ---- hw/scsi_ua_sense.sv ----
// target sense-condition controller: unit attention and aborted command
`timescale 1ns/10ps
`default_nettype none
module scsi_ua_sense #(
  parameter int N_INIT = scsi_sense_pkg::N_INIT,
  parameter int IW = $clog2(N_INIT)
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic bus_reset_pin,
  input wire logic door_open_pin,
  input wire logic manual_pin,
  input wire logic diag_pin,
  input wire logic bdr_stb,
  input wire logic ucode_stb,
  input wire logic mode_sel_stb,
  input wire logic [IW-1:0] mode_sel_init,
  input wire logic cmd_valid,
  input wire logic [IW-1:0] cmd_init,
  input wire logic [7:0] cmd_opcode,
  input wire logic [IW-1:0] evt_init,
  input wire logic abort_msg,
  input wire logic msg_bad_time,
  input wire logic msg_err_late,
  input wire logic fault_stb,
  input wire logic [7:0] fault_where,
  input wire logic parity_nomsg,
  input wire logic rdp_rej_parity,
  input wire logic ide_bad_time,
  input wire logic rdp_rej_ide,
  input wire logic motion_start,
  input wire logic [IW-1:0] motion_init,
  input wire logic motion_done,
  output var logic resp_valid,
  output var scsi_sense_pkg::resp_kind_e resp_kind,
  output var logic [3:0] resp_key,
  output var logic [7:0] resp_asc,
  output var logic [7:0] resp_ascq,
  output var logic motion_abort
);

  ////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;
  logic [3:0] pin_prev_reg;
  logic por_pend_reg;
  logic door_seen_reg;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta_reg <= 4'h0;
      pin_sync_reg <= 4'h0;
      pin_prev_reg <= 4'h0;
    end
    else
    begin
      pin_meta_reg <= {diag_pin, manual_pin, door_open_pin, bus_reset_pin};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  // power-on condition posted once after release
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      por_pend_reg <= 1'b1;
    else
      por_pend_reg <= 1'b0;
  end

  logic bus_rst_edge;
  logic door_closed_edge;
  logic maint_edge;
  assign bus_rst_edge = pin_sync_reg[0] & ~pin_prev_reg[0];
  assign door_closed_edge = ~pin_sync_reg[1] & pin_prev_reg[1] & door_seen_reg;
  assign maint_edge = (pin_sync_reg[2] | pin_sync_reg[3])
    & ~(pin_prev_reg[2] | pin_prev_reg[3]);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      door_seen_reg <= 1'b0;
    else if (pin_sync_reg[1])
      door_seen_reg <= 1'b1;
    else if (door_closed_edge)
      door_seen_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // slots
  sense_slot_if #(.N(N_INIT)) sb ();

  for (genvar g = 0; g < N_INIT; g++)
  begin : g_slot
    ua_slot #(.IDX(g)) u_ua (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .s(sb.slot)
    );
    abort_slot #(.IDX(g)) u_ab (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .s(sb.slot)
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // attention posting, fixed priority when events coincide
  logic reset_evt;
  logic [N_INIT-1:0] all_init;
  logic [N_INIT-1:0] mode_others;
  assign reset_evt = por_pend_reg | bus_rst_edge | bdr_stb;
  assign all_init = {N_INIT{1'b1}};
  assign mode_others = ~(N_INIT'(1) << mode_sel_init);

  always_comb
  begin
    sb.ua_post = '0;
    sb.ua_asc = scsi_sense_pkg::ASC_NONE;
    sb.ua_ascq = scsi_sense_pkg::ASCQ_ZERO;
    if (reset_evt)
    begin
      sb.ua_post = all_init;
      sb.ua_asc = scsi_sense_pkg::ASC_RESET;
      sb.ua_ascq = scsi_sense_pkg::ASCQ_RESET;
    end
    else if (ucode_stb)
    begin
      sb.ua_post = all_init;
      sb.ua_asc = scsi_sense_pkg::ASC_UCODE;
      sb.ua_ascq = scsi_sense_pkg::ASCQ_UCODE;
    end
    else if (door_closed_edge)
    begin
      sb.ua_post = all_init;
      sb.ua_asc = scsi_sense_pkg::ASC_DOOR;
      sb.ua_ascq = scsi_sense_pkg::ASCQ_DOOR;
    end
    else if (maint_edge)
    begin
      sb.ua_post = all_init;
      sb.ua_asc = scsi_sense_pkg::ASC_MANUAL;
      sb.ua_ascq = scsi_sense_pkg::ASCQ_MANUAL;
    end
    else if (mode_sel_stb)
    begin
      sb.ua_post = mode_others;
      sb.ua_asc = scsi_sense_pkg::ASC_MODE;
      sb.ua_ascq = scsi_sense_pkg::ASCQ_MODE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // motion ownership
  logic motion_busy_reg;
  logic [IW-1:0] motion_owner_reg;
  logic motion_clash;
  assign motion_clash = cmd_valid & motion_busy_reg & (cmd_init == motion_owner_reg);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      motion_busy_reg <= 1'b0;
      motion_owner_reg <= '0;
    end
    else if (motion_clash | motion_done)
      motion_busy_reg <= 1'b0;
    else if (motion_start)
    begin
      motion_busy_reg <= 1'b1;
      motion_owner_reg <= motion_init;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // aborted command sense selection
  logic ab_evt;
  logic [N_INIT-1:0] evt_sel;
  logic [N_INIT-1:0] cmd_sel;
  assign evt_sel = N_INIT'(1) << evt_init;
  assign cmd_sel = N_INIT'(1) << cmd_init;
  assign ab_evt = abort_msg | msg_bad_time | msg_err_late | fault_stb
    | parity_nomsg | rdp_rej_parity | ide_bad_time | rdp_rej_ide;

  always_comb
  begin
    sb.ab_post = '0;
    sb.ab_asc = scsi_sense_pkg::ASC_NONE;
    sb.ab_ascq = scsi_sense_pkg::ASCQ_ZERO;
    if (motion_clash)
    begin
      sb.ab_post = cmd_sel;
      sb.ab_asc = scsi_sense_pkg::ASC_MOTION;
    end
    else if (ab_evt)
    begin
      sb.ab_post = evt_sel;
      if (fault_stb)
      begin
        sb.ab_asc = scsi_sense_pkg::ASC_FAULT;
        sb.ab_ascq = fault_where;
      end
      else if (parity_nomsg | rdp_rej_parity)
        sb.ab_asc = scsi_sense_pkg::ASC_PARITY;
      else if (ide_bad_time | rdp_rej_ide)
        sb.ab_asc = scsi_sense_pkg::ASC_IDE;
      else if (msg_bad_time | msg_err_late)
        sb.ab_asc = scsi_sense_pkg::ASC_MSG_TIME;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command decision
  logic ua_p;
  logic ua_r;
  logic is_rs;
  logic is_inq;
  assign ua_p = sb.ua_pend[cmd_init];
  assign ua_r = sb.ua_rep[cmd_init];
  assign is_rs = cmd_opcode == scsi_sense_pkg::OP_REQ_SENSE;
  assign is_inq = cmd_opcode == scsi_sense_pkg::OP_INQUIRY;

  always_comb
  begin
    sb.ua_clr = '0;
    sb.ua_mark = '0;
    sb.ab_clr = '0;
    if (cmd_valid & ~motion_clash)
    begin
      if (is_rs & ua_p)
        sb.ua_clr = cmd_sel;
      else if (is_rs)
        sb.ab_clr = cmd_sel;
      else if (ua_p & ~is_inq & ~ua_r)
        sb.ua_mark = cmd_sel;
      else if (ua_p & ~is_inq)
        sb.ua_clr = cmd_sel;
    end
  end

  logic resp_valid_reg;
  scsi_sense_pkg::resp_kind_e resp_kind_reg;
  logic [3:0] resp_key_reg;
  logic [7:0] resp_asc_reg;
  logic [7:0] resp_ascq_reg;
  logic motion_abort_reg;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      resp_valid_reg <= 1'b0;
      resp_kind_reg <= scsi_sense_pkg::RESP_EXEC;
      resp_key_reg <= scsi_sense_pkg::KEY_NONE;
      resp_asc_reg <= scsi_sense_pkg::ASC_NONE;
      resp_ascq_reg <= scsi_sense_pkg::ASCQ_ZERO;
    end
    else
    begin
      resp_valid_reg <= cmd_valid;
      resp_key_reg <= scsi_sense_pkg::KEY_NONE;
      resp_asc_reg <= scsi_sense_pkg::ASC_NONE;
      resp_ascq_reg <= scsi_sense_pkg::ASCQ_ZERO;
      resp_kind_reg <= scsi_sense_pkg::RESP_EXEC;
      if (motion_clash)
      begin
        resp_kind_reg <= scsi_sense_pkg::RESP_CHECK;
        resp_key_reg <= scsi_sense_pkg::KEY_ABORT;
        resp_asc_reg <= scsi_sense_pkg::ASC_MOTION;
      end
      else if (is_rs & ua_p)
      begin
        resp_kind_reg <= scsi_sense_pkg::RESP_SENSE;
        resp_key_reg <= scsi_sense_pkg::KEY_UA;
        resp_asc_reg <= sb.ua_asc_q[cmd_init];
        resp_ascq_reg <= sb.ua_ascq_q[cmd_init];
      end
      else if (is_rs)
      begin
        resp_kind_reg <= scsi_sense_pkg::RESP_SENSE;
        if (sb.ab_pend[cmd_init])
        begin
          resp_key_reg <= scsi_sense_pkg::KEY_ABORT;
          resp_asc_reg <= sb.ab_asc_q[cmd_init];
          resp_ascq_reg <= sb.ab_ascq_q[cmd_init];
        end
      end
      else if (ua_p & ~is_inq & ~ua_r)
      begin
        resp_kind_reg <= scsi_sense_pkg::RESP_CHECK;
        resp_key_reg <= scsi_sense_pkg::KEY_UA;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      motion_abort_reg <= 1'b0;
    else
      motion_abort_reg <= motion_clash;
  end

  assign resp_valid = resp_valid_reg;
  assign resp_kind = resp_kind_reg;
  assign resp_key = resp_key_reg;
  assign resp_asc = resp_asc_reg;
  assign resp_ascq = resp_ascq_reg;
  assign motion_abort = motion_abort_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence plain_cmd;
    cmd_valid && !motion_clash && sb.ua_post == '0;
  endsequence

  sequence rs_with_ua;
    plain_cmd ##0 is_rs && ua_p;
  endsequence

  chk_por_post: assert property (por_pend_reg |=> &sb.ua_pend &&
    sb.ua_asc_q[0] == scsi_sense_pkg::ASC_RESET)
    else $error("reset did not post attention");

  chk_ucode_post: assert property (ucode_stb && !reset_evt |=>
    sb.ua_asc_q[N_INIT-1] == scsi_sense_pkg::ASC_UCODE
    && sb.ua_ascq_q[N_INIT-1] == scsi_sense_pkg::ASCQ_UCODE)
    else $error("microcode attention wrong");

  chk_mode_others: assert property (mode_sel_stb && !reset_evt && !ucode_stb
    && !door_closed_edge && !maint_edge |=> sb.ua_pend == ($past(sb.ua_pend)
    | $past(mode_others)) || $past(cmd_valid))
    else $error("mode change not posted to others");

  chk_sense_clear: assert property (rs_with_ua |=> resp_key ==
    scsi_sense_pkg::KEY_UA && !sb.ua_pend[$past(cmd_init)])
    else $error("request sense did not clear");

  chk_inquiry_keep: assert property (plain_cmd ##0 is_inq && ua_p |=>
    resp_kind == scsi_sense_pkg::RESP_EXEC && sb.ua_pend[$past(cmd_init)])
    else $error("inquiry disturbed attention");

  chk_ua_reject: assert property (plain_cmd ##0 ua_p && !ua_r && !is_rs
    && !is_inq |=> resp_kind == scsi_sense_pkg::RESP_CHECK
    && sb.ua_pend[$past(cmd_init)] && sb.ua_rep[$past(cmd_init)])
    else $error("unreported attention not checked");

  chk_ua_exec: assert property (plain_cmd ##0 ua_p && ua_r && !is_rs
    && !is_inq |=> resp_kind == scsi_sense_pkg::RESP_EXEC
    && !sb.ua_pend[$past(cmd_init)])
    else $error("reported attention not cleared");

  chk_motion_abort: assert property (motion_clash |=> motion_abort
    && resp_asc == scsi_sense_pkg::ASC_MOTION && !motion_busy_reg ##1 !motion_abort)
    else $error("motion clash not aborted");

  chk_fault_code: assert property (fault_stb && !motion_clash |=>
    sb.ab_asc_q[$past(evt_init)] == scsi_sense_pkg::ASC_FAULT
    && sb.ab_ascq_q[$past(evt_init)] == $past(fault_where))
    else $error("fault sense wrong");

  chk_ua_hold: assert property (sb.ua_pend[0] && !sb.ua_clr[0] |=>
    sb.ua_pend[0])
    else $error("attention dropped");

endmodule // scsi_ua_sense
`default_nettype wire

// ---- hw/scsi_sense_pkg.sv ----
// constants for the unit attention and aborted command sense logic
package scsi_sense_pkg;
  localparam int N_INIT = 8;
  localparam logic [3:0] KEY_NONE = 4'h0;
  localparam logic [3:0] KEY_UA = 4'h6;
  localparam logic [3:0] KEY_ABORT = 4'hb;
  localparam logic [7:0] ASC_NONE = 8'h00;
  localparam logic [7:0] ASC_RESET = 8'h29;
  localparam logic [7:0] ASCQ_RESET = 8'h00;
  localparam logic [7:0] ASC_UCODE = 8'h3f;
  localparam logic [7:0] ASCQ_UCODE = 8'h01;
  localparam logic [7:0] ASC_DOOR = 8'h28;
  localparam logic [7:0] ASCQ_DOOR = 8'h00;
  localparam logic [7:0] ASC_MANUAL = 8'h04;
  localparam logic [7:0] ASCQ_MANUAL = 8'h89;
  localparam logic [7:0] ASC_MODE = 8'h2a;
  localparam logic [7:0] ASCQ_MODE = 8'h01;
  localparam logic [7:0] ASC_MSG_TIME = 8'h43;
  localparam logic [7:0] ASC_FAULT = 8'h44;
  localparam logic [7:0] ASC_PARITY = 8'h47;
  localparam logic [7:0] ASC_IDE = 8'h48;
  localparam logic [7:0] ASC_MOTION = 8'h4e;
  localparam logic [7:0] ASCQ_ZERO = 8'h00;
  localparam logic [7:0] OP_REQ_SENSE = 8'h03;
  localparam logic [7:0] OP_INQUIRY = 8'h12;
  localparam logic [7:0] OP_MODE_SENSE = 8'h1a;
  typedef enum logic [1:0] {RESP_EXEC, RESP_CHECK, RESP_SENSE} resp_kind_e;
endpackage

// ---- hw/sense_slot_if.sv ----
// per-initiator sense slot bus between controller and slots
`timescale 1ns/10ps
`default_nettype none
interface sense_slot_if #(parameter int N = 8);
  logic [N-1:0] ua_post;
  logic [7:0] ua_asc;
  logic [7:0] ua_ascq;
  logic [N-1:0] ua_clr;
  logic [N-1:0] ua_mark;
  logic [N-1:0] ab_post;
  logic [7:0] ab_asc;
  logic [7:0] ab_ascq;
  logic [N-1:0] ab_clr;
  wire [N-1:0] ua_pend;
  wire [N-1:0] ua_rep;
  wire [N-1:0][7:0] ua_asc_q;
  wire [N-1:0][7:0] ua_ascq_q;
  wire [N-1:0] ab_pend;
  wire [N-1:0][7:0] ab_asc_q;
  wire [N-1:0][7:0] ab_ascq_q;
  modport ctl (output ua_post, ua_asc, ua_ascq, ua_clr, ua_mark, ab_post, ab_asc,
    ab_ascq, ab_clr, input ua_pend, ua_rep, ua_asc_q, ua_ascq_q, ab_pend, ab_asc_q,
    ab_ascq_q);
  modport slot (input ua_post, ua_asc, ua_ascq, ua_clr, ua_mark, ab_post, ab_asc,
    ab_ascq, ab_clr, output ua_pend, ua_rep, ua_asc_q, ua_ascq_q, ab_pend, ab_asc_q,
    ab_ascq_q);
endinterface // sense_slot_if
`default_nettype wire

// ---- hw/ua_slot.sv ----
// one initiator's unit attention slot
`timescale 1ns/10ps
`default_nettype none
module ua_slot #(parameter int IDX = 0) (
  input wire logic clk_sys,
  input wire logic rst_n,
  sense_slot_if.slot s
);
  logic pend_reg;
  logic rep_reg;
  logic [7:0] asc_reg;
  logic [7:0] ascq_reg;

  // newest post overwrites, and wins over a clear
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_reg <= 1'b0;
      rep_reg <= 1'b0;
      asc_reg <= scsi_sense_pkg::ASC_NONE;
      ascq_reg <= scsi_sense_pkg::ASCQ_ZERO;
    end
    else if (s.ua_post[IDX])
    begin
      pend_reg <= 1'b1;
      rep_reg <= 1'b0;
      asc_reg <= s.ua_asc;
      ascq_reg <= s.ua_ascq;
    end
    else if (s.ua_clr[IDX])
    begin
      pend_reg <= 1'b0;
      rep_reg <= 1'b0;
    end
    else if (s.ua_mark[IDX])
      rep_reg <= pend_reg;
  end

  assign s.ua_pend[IDX] = pend_reg;
  assign s.ua_rep[IDX] = rep_reg;
  assign s.ua_asc_q[IDX] = asc_reg;
  assign s.ua_ascq_q[IDX] = ascq_reg;
endmodule // ua_slot
`default_nettype wire

// ---- hw/abort_slot.sv ----
// one initiator's aborted command sense slot
`timescale 1ns/10ps
`default_nettype none
module abort_slot #(parameter int IDX = 0) (
  input wire logic clk_sys,
  input wire logic rst_n,
  sense_slot_if.slot s
);
  logic pend_reg;
  logic [7:0] asc_reg;
  logic [7:0] ascq_reg;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_reg <= 1'b0;
      asc_reg <= scsi_sense_pkg::ASC_NONE;
      ascq_reg <= scsi_sense_pkg::ASCQ_ZERO;
    end
    else if (s.ab_post[IDX])
    begin
      pend_reg <= 1'b1;
      asc_reg <= s.ab_asc;
      ascq_reg <= s.ab_ascq;
    end
    else if (s.ab_clr[IDX])
      pend_reg <= 1'b0;
  end

  assign s.ab_pend[IDX] = pend_reg;
  assign s.ab_asc_q[IDX] = asc_reg;
  assign s.ab_ascq_q[IDX] = ascq_reg;
endmodule // abort_slot
`default_nettype wire

// ---- tb/initiator_model.sv ----
// initiator side model: issues commands to the sense logic
`timescale 1ns/10ps
`default_nettype none
module initiator_model (
  input wire logic clk_sys,
  output var logic cmd_valid,
  output var logic [2:0] cmd_init,
  output var logic [7:0] cmd_opcode
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd_init = 3'h0;
    cmd_opcode = 8'h00;
  end

  // one command per cycle, request held until the taking edge
  task automatic issue(input logic [2:0] i, input logic [7:0] op);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_init <= i;
    cmd_opcode <= op;
  endtask

  // released bus shows the inverse so a stale value never passes
  task automatic release_bus();
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    cmd_init <= ~cmd_init;
    cmd_opcode <= ~cmd_opcode;
  endtask

  // after a mode change report, read the new parameters
  task automatic mode_sense(input logic [2:0] i);
    issue(i, scsi_sense_pkg::OP_MODE_SENSE);
  endtask
endmodule // initiator_model
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the unit attention and aborted command logic
`timescale 1ns/10ps
`default_nettype none
module testbench;
  typedef struct packed {
    scsi_sense_pkg::resp_kind_e kind;
    logic [3:0] key;
    logic [7:0] asc;
    logic [7:0] ascq;
    logic mab;
  } exp_s;
  localparam int TIMEOUT = 20000;
  localparam logic [7:0] UA_ASC [6] = '{8'h3f, 8'h28, 8'h04, 8'h04, 8'h29, 8'h29};
  localparam logic [7:0] UA_ASCQ [6] = '{8'h01, 8'h00, 8'h89, 8'h89, 8'h00, 8'h00};
  localparam logic [7:0] AB_ASC [8] = '{8'h00, 8'h43, 8'h43, 8'h44, 8'h47, 8'h47, 8'h48, 8'h48};
  localparam int PIN_OF [6] = '{0, 1, 2, 3, 0, 0};
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] pins = 4'h0;
  logic [12:0] stb = 13'h0000;
  logic [2:0] mode_sel_init = 3'h0;
  logic [2:0] evt_init = 3'h0;
  logic [7:0] fault_where = 8'h00;
  logic [2:0] motion_init = 3'h0;
  wire logic cmd_valid;
  wire logic [2:0] cmd_init;
  wire logic [7:0] cmd_opcode;
  logic resp_valid;
  scsi_sense_pkg::resp_kind_e resp_kind;
  logic [3:0] resp_key;
  logic [7:0] resp_asc;
  logic [7:0] resp_ascq;
  logic motion_abort;
  exp_s exp_q[$];
  exp_s mon_e;
  logic cmd_d1 = 1'b0;
  logic [31:0] lfsr = 32'h0000_b1ca;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;

  always #25 clk_sys = ~clk_sys;

  initiator_model u_host (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_init(cmd_init),
    .cmd_opcode(cmd_opcode));

  scsi_ua_sense u_dut (.clk_sys(clk_sys), .rstn(rstn), .bus_reset_pin(pins[0]),
    .door_open_pin(pins[1]), .manual_pin(pins[2]), .diag_pin(pins[3]), .bdr_stb(stb[8]),
    .ucode_stb(stb[9]), .mode_sel_stb(stb[10]), .mode_sel_init(mode_sel_init),
    .cmd_valid(cmd_valid), .cmd_init(cmd_init), .cmd_opcode(cmd_opcode),
    .evt_init(evt_init), .abort_msg(stb[0]), .msg_bad_time(stb[1]), .msg_err_late(stb[2]),
    .fault_stb(stb[3]), .fault_where(fault_where), .parity_nomsg(stb[4]),
    .rdp_rej_parity(stb[5]), .ide_bad_time(stb[6]), .rdp_rej_ide(stb[7]),
    .motion_start(stb[11]), .motion_init(motion_init), .motion_done(stb[12]),
    .resp_valid(resp_valid), .resp_kind(resp_kind), .resp_key(resp_key),
    .resp_asc(resp_asc), .resp_ascq(resp_ascq), .motion_abort(motion_abort));

  ////////////////////////////////////////////////////////////////////////////
  task automatic rnd(output logic [31:0] r);
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    r = lfsr;
  endtask

  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmd(input logic [2:0] i, input logic [7:0] op,
    input scsi_sense_pkg::resp_kind_e k, input logic [3:0] key, input logic [7:0] asc,
    input logic [7:0] ascq, input logic mab = 1'b0);
    exp_q.push_back(exp_s'{k, key, asc, ascq, mab});
    u_host.issue(i, op);
  endtask

  task automatic rsense(input logic [2:0] i, input logic [3:0] key, input logic [7:0] asc,
    input logic [7:0] ascq);
    cmd(i, scsi_sense_pkg::OP_REQ_SENSE, scsi_sense_pkg::RESP_SENSE, key, asc, ascq);
  endtask

  task automatic other(input logic [2:0] i, input scsi_sense_pkg::resp_kind_e k,
    input logic [3:0] key);
    logic [31:0] r;
    rnd(r);
    if (r[7:0] == 8'h03 || r[7:0] == 8'h12)
      r[7:0] = 8'h00;
    cmd(i, r[7:0], k, key, 8'h00, 8'h00);
  endtask

  task automatic pulse(input int n);
    @(posedge clk_sys);
    stb <= 13'h0001 << n;
    @(posedge clk_sys);
    stb <= 13'h0000;
  endtask

  task automatic pin(input int n, input logic v);
    @(posedge clk_sys);
    pins[n] <= v;
    repeat (6) @(posedge clk_sys);
  endtask

  task automatic fire(input int k);
    if (k == 0)
      pulse(9);
    else if (k == 4)
      pulse(8);
    else
    begin
      pin(PIN_OF[k], 1'b1);
      pin(PIN_OF[k], 1'b0);
    end
  endtask

  // every initiator reports the same condition once, then the first one reports none left
  task automatic clear_all(input logic [7:0] asc, input logic [7:0] ascq);
    logic [31:0] r;
    rnd(r);
    for (int j = 0; j < 8; j++)
      rsense(3'(r[2:0] + j), scsi_sense_pkg::KEY_UA, asc, ascq);
    rsense(r[2:0], scsi_sense_pkg::KEY_NONE, 8'h00, 8'h00);
    u_host.release_bus();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys)
  begin
    cmd_d1 <= cmd_valid;
    cycles++;
    if (cycles == TIMEOUT)
    begin
      num_errors++;
      $display("ERROR timeout expected done seen running");
      stop_test();
    end
  end

  always @(negedge clk_sys)
  begin
    mon_e = '0;
    check8("resp_valid", {7'h00, cmd_d1}, {7'h00, resp_valid});
    if (resp_valid === 1'b1 && exp_q.size() > 0)
    begin
      mon_e = exp_q.pop_front();
      check8("resp_kind", {6'h00, mon_e.kind}, {6'h00, resp_kind});
      check8("resp_key", {4'h0, mon_e.key}, {4'h0, resp_key});
      check8("resp_asc", mon_e.asc, resp_asc);
      check8("resp_ascq", mon_e.ascq, resp_ascq);
    end
    check8("motion_abort", {7'h00, mon_e.mab}, {7'h00, motion_abort});
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] r;
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (6) @(posedge clk_sys);
    cmd(3'h1, 8'h12, scsi_sense_pkg::RESP_EXEC, 4'h0, 8'h00, 8'h00);
    other(3'h1, scsi_sense_pkg::RESP_CHECK, 4'h6);
    cmd(3'h1, 8'h12, scsi_sense_pkg::RESP_EXEC, 4'h0, 8'h00, 8'h00);
    other(3'h1, scsi_sense_pkg::RESP_EXEC, 4'h0);
    rsense(3'h1, 4'h0, 8'h00, 8'h00);
    other(3'h2, scsi_sense_pkg::RESP_CHECK, 4'h6);
    other(3'h2, scsi_sense_pkg::RESP_EXEC, 4'h0);
    rsense(3'h2, 4'h0, 8'h00, 8'h00);
    for (int i = 0; i < 8; i++)
      if (i != 1 && i != 2)
        rsense(3'(i), 4'h6, 8'h29, 8'h00);
    u_host.release_bus();
    fire(0);
    fire(1);
    clear_all(8'h28, 8'h00);
    for (int k = 0; k < 6; k++)
    begin
      fire(k);
      clear_all(UA_ASC[k], UA_ASCQ[k]);
    end
    mode_sel_init <= 3'h2;
    pulse(10);
    rsense(3'h2, 4'h0, 8'h00, 8'h00);
    for (int i = 0; i < 8; i++)
      if (i != 2)
      begin
        rsense(3'(i), 4'h6, 8'h2a, 8'h01);
        exp_q.push_back(exp_s'{scsi_sense_pkg::RESP_EXEC, 4'h0, 8'h00, 8'h00, 1'b0});
        u_host.mode_sense(3'(i));
      end
    u_host.release_bus();
    for (int n = 0; n < 8; n++)
    begin
      rnd(r);
      evt_init <= r[2:0];
      fault_where <= r[15:8];
      pulse(n);
      rsense(r[2:0], 4'hb, AB_ASC[n], (n == 3) ? r[15:8] : 8'h00);
      rsense(r[2:0], 4'h0, 8'h00, 8'h00);
      u_host.release_bus();
    end
    motion_init <= 3'h5;
    pulse(11);
    other(3'h3, scsi_sense_pkg::RESP_EXEC, 4'h0);
    cmd(3'h5, 8'h00, scsi_sense_pkg::RESP_CHECK, 4'hb, 8'h4e, 8'h00, 1'b1);
    other(3'h5, scsi_sense_pkg::RESP_EXEC, 4'h0);
    rsense(3'h5, 4'hb, 8'h4e, 8'h00);
    u_host.release_bus();
    motion_init <= 3'h6;
    pulse(11);
    pulse(12);
    other(3'h6, scsi_sense_pkg::RESP_EXEC, 4'h0);
    u_host.release_bus();
    repeat (4) @(posedge clk_sys);
    check8("queue_left", 8'h00, 8'(exp_q.size()));
    stop_test();
  end
endmodule // testbench
`default_nettype wire
